// *** shared/cocl_pkg.sv ***
package cocl_pkg;

  // Register numbers carried in the address field of a write.
  localparam logic [3:0] REG_CH_FIRST = 4'h0;
  localparam logic [3:0] REG_CH_LAST = 4'h7;
  localparam logic [3:0] REG_BOOST = 4'h9;
  localparam logic [3:0] REG_GLOBAL = 4'hE;

  // Field positions inside a channel register.
  localparam int SOFT_RESET_BIT = 31;
  localparam int PATH_HI = 18;
  localparam int PATH_LO = 17;
  localparam int EN_BIT = 16;
  localparam int DIV_HI = 15;
  localparam int DIV_LO = 8;
  localparam int DLY_HI = 7;
  localparam int DLY_LO = 4;

  // Field positions inside the boost and global registers.
  localparam int BOOST_BIT = 16;
  localparam int SRC_BIT = 29;
  localparam int GEN_BIT = 27;
  localparam int SLEEP_BIT = 26;

  // Fixed patterns the host writes around the configurable fields.
  localparam logic [31:0] BOOST_FIXED = 32'h0002_2A09;
  localparam logic [31:0] GLOBAL_FIXED = 32'h4000_000E;

  // Values after reset.
  localparam logic [1:0] PATH_RST = 2'h0;
  localparam logic [7:0] DIV_RST = 8'h01;
  localparam logic [3:0] DLY_RST = 4'h0;
  localparam logic EN_RST = 1'b0;
  localparam logic GEN_RST = 1'b1;
  localparam logic SLEEP_RST = 1'b0;
  localparam logic SRC_RST = 1'b0;
  localparam logic BOOST_RST = 1'b0;

  // Path modes.
  typedef enum logic [1:0] {
    COCL_BYPASS = 2'h0,
    COCL_DIVIDE = 2'h1,
    COCL_DELAY = 2'h2,
    COCL_DIV_DLY = 2'h3
  } cocl_path_t;

  // Fixed latencies in ps and the delay step in ps.
  localparam int LAT_DIV_PS = 100;
  localparam int LAT_DLY_PS = 400;
  localparam int LAT_DIV_DLY_PS = 500;
  localparam int DLY_STEP_PS = 150;

endpackage : cocl_pkg

// *** shared/cocl_if.sv ***
`timescale 1ns/1ps
// Write-only configuration link: one 32-bit word plus a register number per strobe.
interface cocl_if;
  logic wr_stb;
  logic [3:0] wr_reg;
  logic [31:0] wr_data;
  logic sync_pulse;

  modport dev (input wr_stb, input wr_reg, input wr_data, input sync_pulse);
  modport host (output wr_stb, output wr_reg, output wr_data, output sync_pulse);
endinterface : cocl_if

// *** src/cocl_host.sv ***
`timescale 1ns/1ps
// Host end: turns user write requests into link writes, adding the fixed patterns.
module cocl_host (
  input wire logic core_clk,
  input wire logic rst_n,
  cocl_if.host link,
  input wire logic req_valid,
  input wire logic [3:0] req_reg,
  input wire logic [31:0] req_data,
  input wire logic req_sync,
  output logic req_busy
);

  logic stb_r;
  logic [3:0] reg_r;
  logic [31:0] data_r;
  logic sync_r;

  ////////////////////////////////////////////////////////////////////////////
  // One write per cycle; fixed bits are forced so the device is never mis-set.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      stb_r <= 1'b0;
      reg_r <= 4'h0;
      data_r <= 32'h0000_0000;
    end
    else
    begin
      stb_r <= req_valid;
      reg_r <= req_reg;
      if (req_reg == cocl_pkg::REG_BOOST)
        data_r <= cocl_pkg::BOOST_FIXED | (req_data & (32'h1 << cocl_pkg::BOOST_BIT));
      else if (req_reg == cocl_pkg::REG_GLOBAL)
        data_r <= cocl_pkg::GLOBAL_FIXED | (req_data & 32'h2C00_0000);
      else if (req_reg == cocl_pkg::REG_CH_FIRST)
        data_r <= req_data; // Soft reset bit passes only when asked for.
      else
        data_r <= req_data & 32'h7FFF_FFFF;
    end
  end

  // Sync pulse is issued by the user after all dividers are written.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sync_r <= 1'b0;
    else
      sync_r <= req_sync;
  end

  assign link.wr_stb = stb_r;
  assign link.wr_reg = reg_r;
  assign link.wr_data = data_r;
  assign link.sync_pulse = sync_r;
  assign req_busy = 1'b0;

endmodule : cocl_host

// *** src/cocl_dev.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Soft reset bit restores all defaults, self-clears.
// - Soft reset write ignores other fields.
// - Host keeps soft reset bit zero normally.
// - Path select: bypass, divide, delay, both.
// - Modes add 0/100/400/500 ps latency.
// - Divider active only in divide modes.
// - Divide ratio is twice code; zero invalid.
// - Host pulses sync after writing dividers.
// - Delay active only in delay modes.
// - Delay is 150 ps per code step.
// - Output needs enable, global enable, gate high.
// - Global enable zero disables all outputs.
// - Power-down overrides everything.
// - Source bit zero picks second input.
// - Boost bit sets boost on all outputs.
// - Host writes boost register with fixed bits.
// - Host writes global register with fixed pattern.
// - Channel fields at 18:17, 16, 15:8, 7:4.
// - Soft reset at bit 31 of channel zero.
// - Global fields at bits 29, 27, 26.
module cocl_dev #(
  parameter int NCH = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  cocl_if.dev link,
  input wire logic first_ref_input,
  input wire logic second_ref_input,
  input wire logic output_gate_pin,
  output logic [NCH-1:0] clk_out,
  output logic [NCH-1:0] chan_active,
  output logic [NCH-1:0][1:0] chan_path,
  output logic [NCH-1:0][3:0] chan_delay,
  output logic [NCH-1:0][9:0] chan_latency_tenps,
  output logic swing_boost,
  output logic device_asleep,
  output logic source_sel
);

  logic [NCH-1:0][1:0] channel_path_select_r;
  logic [NCH-1:0][7:0] channel_divide_code_r;
  logic [NCH-1:0][3:0] channel_delay_code_r;
  logic [NCH-1:0] channel_output_enable_r;
  logic all_outputs_enable_r;
  logic full_device_sleep_r;
  logic input_source_pick_r;
  logic boost_r;
  logic soft_rst;
  logic ref_clk;
  logic sync_d_r;

  // Active divide modes and delay modes, decoded once.
  function automatic logic uses_div(input logic [1:0] p);
    uses_div = p[0];
  endfunction : uses_div

  function automatic logic uses_dly(input logic [1:0] p);
    uses_dly = p[1];
  endfunction : uses_dly

  // Fixed latency in units of 10 ps for a path and delay code.
  function automatic logic [9:0] latency(input logic [1:0] p, input logic [3:0] d);
    logic [9:0] l;
    l = 10'h000;
    unique case (cocl_pkg::cocl_path_t'(p))
      cocl_pkg::COCL_BYPASS: l = 10'h000;
      cocl_pkg::COCL_DIVIDE: l = 10'(cocl_pkg::LAT_DIV_PS / 10);
      cocl_pkg::COCL_DELAY: l = 10'(cocl_pkg::LAT_DLY_PS / 10 + (cocl_pkg::DLY_STEP_PS / 10) * d);
      cocl_pkg::COCL_DIV_DLY: l = 10'(cocl_pkg::LAT_DIV_DLY_PS / 10 + (cocl_pkg::DLY_STEP_PS / 10) * d);
    endcase
    latency = l;
  endfunction : latency

  ////////////////////////////////////////////////////////////////////////////
  // A channel zero write with bit 31 set acts as a soft reset.
  assign soft_rst = link.wr_stb && link.wr_reg == cocl_pkg::REG_CH_FIRST
                    && link.wr_data[cocl_pkg::SOFT_RESET_BIT];

  // Input clock selection.
  assign ref_clk = input_source_pick_r ? first_ref_input : second_ref_input;

  ////////////////////////////////////////////////////////////////////////////
  // Global and boost registers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || soft_rst)
    begin
      all_outputs_enable_r <= cocl_pkg::GEN_RST;
      full_device_sleep_r <= cocl_pkg::SLEEP_RST;
      input_source_pick_r <= cocl_pkg::SRC_RST;
      boost_r <= cocl_pkg::BOOST_RST;
    end
    else if (link.wr_stb && link.wr_reg == cocl_pkg::REG_GLOBAL)
    begin
      all_outputs_enable_r <= link.wr_data[cocl_pkg::GEN_BIT];
      full_device_sleep_r <= link.wr_data[cocl_pkg::SLEEP_BIT];
      input_source_pick_r <= link.wr_data[cocl_pkg::SRC_BIT];
    end
    else if (link.wr_stb && link.wr_reg == cocl_pkg::REG_BOOST)
      boost_r <= link.wr_data[cocl_pkg::BOOST_BIT];
  end

  // Sync edge shared by all dividers.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sync_d_r <= 1'b0;
    else
      sync_d_r <= link.sync_pulse;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel registers, dividers and output gating.
  for (genvar i = 0; i < NCH; i++)
  begin : g_ch
    logic [8:0] cnt_r;
    logic [7:0] div_live_r;
    logic half_r;
    logic out_r;
    logic en_now;
    logic src_bit;

    // Channel register; soft reset ignores the rest of the word.
    always_ff @(posedge core_clk)
    begin
      if (!rst_n || soft_rst)
      begin
        channel_path_select_r[i] <= cocl_pkg::PATH_RST;
        channel_output_enable_r[i] <= cocl_pkg::EN_RST;
        channel_divide_code_r[i] <= cocl_pkg::DIV_RST;
        channel_delay_code_r[i] <= cocl_pkg::DLY_RST;
      end
      else if (link.wr_stb && link.wr_reg == 4'(i))
      begin
        channel_path_select_r[i] <= link.wr_data[cocl_pkg::PATH_HI:cocl_pkg::PATH_LO];
        channel_output_enable_r[i] <= link.wr_data[cocl_pkg::EN_BIT];
        if (link.wr_data[cocl_pkg::DIV_HI:cocl_pkg::DIV_LO] != 8'h00) // Zero code rejected.
          channel_divide_code_r[i] <= link.wr_data[cocl_pkg::DIV_HI:cocl_pkg::DIV_LO];
        channel_delay_code_r[i] <= link.wr_data[cocl_pkg::DLY_HI:cocl_pkg::DLY_LO];
      end
    end

    // Half-period counter of length code, toggling gives ratio twice the code.
    // New codes load only at a half-period end so no runt pulse appears.
    always_ff @(posedge core_clk)
    begin
      if (!rst_n || sync_d_r)
      begin
        cnt_r <= 9'h001;
        half_r <= 1'b0;
        div_live_r <= cocl_pkg::DIV_RST;
      end
      else if (cnt_r >= {1'b0, div_live_r})
      begin
        cnt_r <= 9'h001;
        half_r <= ~half_r;
        div_live_r <= channel_divide_code_r[i];
      end
      else
        cnt_r <= 9'(cnt_r + 9'h001);
    end

    assign en_now = channel_output_enable_r[i] && all_outputs_enable_r && output_gate_pin
                    && !full_device_sleep_r;
    assign src_bit = uses_div(channel_path_select_r[i]) ? half_r : ref_clk;

    // Registered outputs.
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        out_r <= 1'b0;
        chan_active[i] <= 1'b0;
        chan_path[i] <= cocl_pkg::PATH_RST;
        chan_delay[i] <= cocl_pkg::DLY_RST;
        chan_latency_tenps[i] <= 10'h000;
      end
      else
      begin
        out_r <= en_now & src_bit;
        chan_active[i] <= en_now;
        chan_path[i] <= channel_path_select_r[i];
        chan_delay[i] <= uses_dly(channel_path_select_r[i]) ? channel_delay_code_r[i] : 4'h0;
        chan_latency_tenps[i] <= latency(channel_path_select_r[i], channel_delay_code_r[i]);
      end
    end

    assign clk_out[i] = out_r;
  end

  // Device-wide status outputs.
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      swing_boost <= 1'b0;
      device_asleep <= 1'b0;
      source_sel <= 1'b0;
    end
    else
    begin
      swing_boost <= boost_r && !full_device_sleep_r;
      device_asleep <= full_device_sleep_r;
      source_sel <= input_source_pick_r;
    end
  end

endmodule : cocl_dev

// *** tb/cocl_checker.sv ***
`timescale 1ns/1ps
// Watches the writes that the host end puts on the link.
module cocl_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic wr_stb,
  input wire logic [3:0] wr_reg,
  input wire logic [31:0] wr_data,
  input wire logic sync_pulse
);
  ////////////////////////////////
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // A write to the global or the boost register.
  sequence glob_wr;
    wr_stb && wr_reg == cocl_pkg::REG_GLOBAL;
  endsequence
  sequence boost_wr;
    wr_stb && wr_reg == cocl_pkg::REG_BOOST;
  endsequence

  ////////////////////////////////
  a_glob_fixed: assert property (
    glob_wr |-> (wr_data & cocl_pkg::GLOBAL_FIXED) == cocl_pkg::GLOBAL_FIXED)
    else $error("global write lacks fixed bits");
  a_boost_fixed: assert property (
    boost_wr |-> (wr_data & cocl_pkg::BOOST_FIXED) == cocl_pkg::BOOST_FIXED)
    else $error("boost write lacks fixed bits");
  a_sync_one_cycle: assert property (
    $rose(sync_pulse) |=> !sync_pulse)
    else $error("sync pulse longer than one cycle");
  a_quiet_in_reset: assert property (disable iff (1'b0)
    !rst_n |=> !wr_stb && !sync_pulse)
    else $error("link active after reset edge");
  // Outside the fixed pattern only the source, enable and sleep fields may be set.
  a_glob_no_stray: assert property (
    glob_wr |-> (wr_data & ~(cocl_pkg::GLOBAL_FIXED | 32'h2C00_0000)) == 32'h0000_0000)
    else $error("global write sets a stray bit");
  // Outside the fixed pattern only the boost bit may be set.
  a_boost_no_stray: assert property (
    boost_wr |-> (wr_data & ~(cocl_pkg::BOOST_FIXED | 32'h0001_0000)) == 32'h0000_0000)
    else $error("boost write sets a stray bit");
  // The soft reset bit is only ever sent to channel register zero.
  a_rst_bit_ch0: assert property (
    wr_stb && wr_reg != cocl_pkg::REG_CH_FIRST |-> !wr_data[cocl_pkg::SOFT_RESET_BIT])
    else $error("reset bit set outside channel zero");
endmodule : cocl_checker

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic [3:0] req_reg = 4'h0;
  logic [31:0] req_data = 32'h0;
  logic req_sync = 1'b0;
  logic gate = 1'b1;
  logic [7:0] clk_out;
  logic [7:0] chan_active;
  logic [7:0][1:0] chan_path;
  logic [7:0][3:0] chan_delay;
  logic [7:0][9:0] lat;
  logic swing_boost, device_asleep, source_sel;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int p;
  int fx[4] = '{0, 10, 40, 50};
  cocl_if lnk ();
  cocl_host cocl_host_i (.core_clk(core_clk), .rst_n(rst_n), .link(lnk), .req_valid(req_valid),
    .req_reg(req_reg), .req_data(req_data), .req_sync(req_sync), .req_busy());
  cocl_dev cocl_dev_i (.core_clk(core_clk), .rst_n(rst_n), .link(lnk), .first_ref_input(1'b1),
    .second_ref_input(1'b0), .output_gate_pin(gate), .clk_out(clk_out), .chan_active(chan_active),
    .chan_path(chan_path), .chan_delay(chan_delay), .chan_latency_tenps(lat),
    .swing_boost(swing_boost), .device_asleep(device_asleep), .source_sel(source_sel));
  cocl_checker cocl_checker_i (.core_clk(core_clk), .rst_n(rst_n), .wr_stb(lnk.wr_stb),
    .wr_reg(lnk.wr_reg), .wr_data(lnk.wr_data), .sync_pulse(lnk.sync_pulse));
  `define CHK(n, e, s) chk(n, 64'(e), 64'(s))
  ////////////////////////////////
  // Clock and the cycle limit that cuts a hang short.
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  ////////////////////////////////
  // Compares one value and counts the result.
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    checks_done++;
    if (s !== e)
    begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : chk
  // One register write, then waits until the outputs reflect it.
  task automatic wr(input logic [3:0] r, input logic [31:0] d);
    @(posedge core_clk);
    req_valid <= 1'b1;
    req_reg <= r;
    req_data <= d;
    @(posedge core_clk);
    req_valid <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
  endtask : wr
  // Channel word from path, enable, divide and delay.
  function automatic logic [31:0] ch(int m, int en, int dv, int dl);
    return 32'(m) << 17 | 32'(en) << 16 | 32'(dv) << 8 | 32'(dl) << 4;
  endfunction : ch
  // Cycles between two rising edges of one output, after one settling period.
  task automatic period(input int i, output int q);
    time t0;
    @(posedge clk_out[i]);
    @(posedge clk_out[i]);
    t0 = $time;
    @(posedge clk_out[i]);
    q = int'(($time - t0) / 4);
  endtask : period
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test
  ////////////////////////////////
  // Main sequence of tests.
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK("active", 8'h00, chan_active);
    `CHK("path", 16'h0, chan_path);
    `CHK("asleep", 1'b0, device_asleep);
    `CHK("source", 1'b0, source_sel);
    $display("test defaults done");
    for (int i = 0; i < 8; i++)
    begin
      wr(4'(i), ch(i % 4, 1, 2, 2 * i + 1));
      `CHK("path", i % 4, chan_path[i]);
      `CHK("delay", (i % 4 >= 2) ? 2 * i + 1 : 0, chan_delay[i]);
      `CHK("latency", fx[i % 4] + ((i % 4 >= 2) ? (2 * i + 1) * 15 : 0), lat[i]);
    end
    `CHK("active", 8'hFF, chan_active);
    `CHK("ref", 8'h00, clk_out & 8'h55);
    $display("test modes done");
    @(posedge core_clk);
    gate <= 1'b0;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK("active", 8'h00, chan_active);
    `CHK("clk", 8'h00, clk_out);
    @(posedge core_clk);
    gate <= 1'b1;
    wr(cocl_pkg::REG_GLOBAL, 32'h0);
    `CHK("active", 8'h00, chan_active);
    `CHK("source", 1'b0, source_sel);
    `CHK("clk", 8'h00, clk_out);
    wr(cocl_pkg::REG_GLOBAL, 32'h2800_0000);
    `CHK("active", 8'hFF, chan_active);
    `CHK("source", 1'b1, source_sel);
    `CHK("ref", 8'h55, clk_out & 8'h55);
    wr(cocl_pkg::REG_BOOST, 32'h0001_0000);
    `CHK("boost", 1'b1, swing_boost);
    wr(cocl_pkg::REG_GLOBAL, 32'h2C00_0000);
    `CHK("asleep", 1'b1, device_asleep);
    `CHK("active", 8'h00, chan_active);
    `CHK("boost", 1'b0, swing_boost);
    `CHK("clk", 8'h00, clk_out);
    wr(cocl_pkg::REG_GLOBAL, 32'h2800_0000);
    `CHK("asleep", 1'b0, device_asleep);
    `CHK("boost", 1'b1, swing_boost);
    $display("test global done");
    @(posedge core_clk);
    req_sync <= 1'b1;
    @(posedge core_clk);
    req_sync <= 1'b0;
    period(1, p);
    `CHK("period", 4, p);
    wr(4'h1, ch(1, 1, 3, 0));
    period(1, p);
    `CHK("period", 6, p);
    wr(4'h1, ch(1, 1, 0, 0));
    period(1, p);
    `CHK("period", 6, p);
    $display("test divider done");
    wr(4'hA, 32'hFFFF_FFFF);
    `CHK("active", 8'hFF, chan_active);
    wr(4'h0, 32'h8000_0000 | ch(3, 1, 5, 5));
    `CHK("active", 8'h00, chan_active);
    `CHK("path", 16'h0, chan_path);
    `CHK("source", 1'b0, source_sel);
    `CHK("latency", 0, lat[3]);
    `CHK("boost", 1'b0, swing_boost);
    wr(4'h0, ch(1, 1, 1, 0));
    `CHK("active", 8'h01, chan_active);
    $display("test soft reset done");
    finish_test();
  end
endmodule : testbench
